// ==== uart_modem_pin_interface.sv ====
// quad uart pin-level block: interrupt pins, serial lines, modem handshakes
//
// How it works
// - in strobe bus mode a high interrupt select keeps all channel interrupt pins driven.
// - in strobe bus mode with interrupt select low a channel interrupt pin is driven only while its control bit 3 is set.
// - interrupt select only matters when the bus-type input picks the strobe bus.
// - a strap parameter builds the block with interrupt select tied high or tied low.
// - with control bit 6 clear the transmit line is standard and sits high in reset and idle.
// - with control bit 6 set both directions go through the infrared coder, transmit idling low.
// - clear-to-send can hold the transmitter when automatic mode is on, else is a plain input.
// - data-terminal-ready is an active-low output software drives freely.
// - data-set-ready is only reported, never touching transmit or receive.
// - bus-type high means strobe bus, low means single-chip-select bus.
// - in strobe bus mode with interrupt select low an interrupt pin floats while control bit 3 is 0 and drives when 1.
`timescale 1ns/1ns
`default_nettype none
module uart_modem_pin_interface #(
  parameter int NUM_CH = uart_pin_pkg::NUM_CH,
  parameter int FIFO_DEPTH = uart_pin_pkg::FIFO_DEPTH,
  parameter int BIT_CLKS = uart_pin_pkg::BIT_CLKS,
  parameter logic [1:0] INTERRUPT_SELECT_PIN_STRAP = uart_pin_pkg::STRAP_PIN
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic bus_type_i,
  input wire logic interrupt_select_pin_i,
  input wire logic [NUM_CH-1:0][7:0] modem_control_reg_i,
  input wire logic [NUM_CH-1:0][7:0] enhanced_feature_reg_i,
  input wire logic [NUM_CH-1:0][7:0] interrupt_enable_reg_i,
  input wire logic [NUM_CH-1:0] irq_req_i,
  input wire logic [NUM_CH-1:0][7:0] tx_data_i,
  input wire logic [NUM_CH-1:0] tx_valid_i,
  output logic [NUM_CH-1:0] tx_ready_o,
  output logic [NUM_CH-1:0][7:0] rx_data_o,
  output logic [NUM_CH-1:0] rx_valid_o,
  input wire logic [NUM_CH-1:0] rx_ready_i,
  input wire uart_pin_pkg::modem_in_t [NUM_CH-1:0] modem_in_i,
  output uart_pin_pkg::modem_out_t [NUM_CH-1:0] modem_out_o,
  output uart_pin_pkg::chan_status_t [NUM_CH-1:0] status_o
);

  localparam int TW = $clog2(BIT_CLKS);

  // ---------------------------------------------------------------
  // interrupt-select source
  // ---------------------------------------------------------------
  logic int_sel;

  always_comb
  begin
    case (INTERRUPT_SELECT_PIN_STRAP)
      uart_pin_pkg::STRAP_HIGH: int_sel = 1'b1;
      uart_pin_pkg::STRAP_LOW: int_sel = 1'b0;
      default: int_sel = interrupt_select_pin_i;
    endcase
  end

  // ---------------------------------------------------------------
  // per-channel logic
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [7:0] modem_control_reg;
      logic infrared;
      logic cts_hold;
      logic [7:0] fifo_data;
      logic fifo_valid;
      logic fifo_ready;
      logic tx_line;
      logic rx_line;
      logic tick_end;

      uart_pin_pkg::ser_state_t rstate_r, rstate_nxt;
      logic [7:0] rshift_r, rshift_nxt;
      logic [2:0] rbit_r, rbit_nxt;
      logic [TW-1:0] rtick_r, rtick_nxt;
      logic [TW-1:0] ir_cnt_r, ir_cnt_nxt;
      logic [7:0] rdata_r, rdata_nxt;
      logic rvalid_r, rvalid_nxt;
      logic ferr_r, ferr_nxt;
      logic ovr_r, ovr_nxt;
      uart_pin_pkg::modem_out_t pins_r, pins_nxt;
      uart_pin_pkg::chan_status_t stat_r, stat_nxt;

      assign modem_control_reg = modem_control_reg_i[ch];
      assign infrared = modem_control_reg[uart_pin_pkg::MCR_IR_BIT];
      // held only when automatic mode is on and far end is not clear
      assign cts_hold = enhanced_feature_reg_i[ch][uart_pin_pkg::EFR_AUTO_CTS_BIT]
                        && modem_in_i[ch].cts_n;

      uart_tx_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
      ) u_fifo (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .in_data_i(tx_data_i[ch]),
        .in_valid_i(tx_valid_i[ch]),
        .in_ready_o(tx_ready_o[ch]),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready)
      );

      uart_serial_tx #(
        .BIT_CLKS(BIT_CLKS),
        .IR_PULSE_CLKS(uart_pin_pkg::IR_PULSE_CLKS)
      ) u_tx (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .infrared_i(infrared),
        .cts_hold_i(cts_hold),
        .data_i(fifo_data),
        .valid_i(fifo_valid),
        .ready_o(fifo_ready),
        .tx_o(tx_line)
      );

      // infrared decode: a pulse marks a zero bit, stretched over one bit time
      assign rx_line = infrared ? (ir_cnt_r == '0) : modem_in_i[ch].rx;
      assign tick_end = (rtick_r == TW'(BIT_CLKS - 1));

      always_comb
      begin
        rstate_nxt = rstate_r;
        rshift_nxt = rshift_r;
        rbit_nxt = rbit_r;
        rtick_nxt = tick_end ? '0 : rtick_r + 1'b1;
        rdata_nxt = rdata_r;
        ferr_nxt = 1'b0;
        ovr_nxt = 1'b0;
        ir_cnt_nxt = ir_cnt_r;
        if (infrared && modem_in_i[ch].rx)
        begin
          ir_cnt_nxt = TW'(BIT_CLKS - 1);
        end
        else if (ir_cnt_r != '0)
        begin
          ir_cnt_nxt = ir_cnt_r - 1'b1;
        end
        // consumer clear loses to a new byte landing in the same cycle
        rvalid_nxt = rvalid_r && !rx_ready_i[ch];
        case (rstate_r)
          uart_pin_pkg::SER_IDLE:
          begin
            rtick_nxt = '0;
            if (!rx_line)
            begin
              rstate_nxt = uart_pin_pkg::SER_START;
            end
          end
          uart_pin_pkg::SER_START:
          begin
            if (rtick_r == TW'(uart_pin_pkg::RX_MID_CLKS - 1))
            begin
              rtick_nxt = '0;
              rbit_nxt = '0;
              // glitch shorter than half a bit is not a start
              rstate_nxt = rx_line ? uart_pin_pkg::SER_IDLE : uart_pin_pkg::SER_DATA;
            end
          end
          uart_pin_pkg::SER_DATA:
          begin
            if (tick_end)
            begin
              rshift_nxt = {rx_line, rshift_r[7:1]};
              rbit_nxt = rbit_r + 1'b1;
              if (rbit_r == 3'h7)
              begin
                rstate_nxt = uart_pin_pkg::SER_STOP;
              end
            end
          end
          uart_pin_pkg::SER_STOP:
          begin
            if (tick_end)
            begin
              rstate_nxt = uart_pin_pkg::SER_IDLE;
              if (rx_line)
              begin
                ovr_nxt = rvalid_r && !rx_ready_i[ch];
                rdata_nxt = rshift_r;
                rvalid_nxt = 1'b1;
              end
              else
              begin
                ferr_nxt = 1'b1;
              end
            end
          end
          default:
          begin
            rstate_nxt = uart_pin_pkg::SER_IDLE;
          end
        endcase
      end

      // pins and status
      always_comb
      begin
        pins_nxt.tx = tx_line;
        pins_nxt.dtr_n = !modem_control_reg[uart_pin_pkg::MCR_DTR_BIT];
        // automatic mode lifts request-to-send while the receive slot is full
        pins_nxt.rts_n = !modem_control_reg[uart_pin_pkg::MCR_RTS_BIT]
                         || (enhanced_feature_reg_i[ch][uart_pin_pkg::EFR_AUTO_RTS_BIT]
                             && rvalid_r);
        pins_nxt.irq = irq_req_i[ch];
        pins_nxt.irq_oe = 1'b0;
        if (bus_type_i)
        begin
          pins_nxt.irq_oe = int_sel || modem_control_reg[uart_pin_pkg::MCR_INT_EN_BIT];
        end
        else if (ch == 0)
        begin
          // single-chip-select mode: channel 0 is a shared open-drain low
          pins_nxt.irq = 1'b0;
          pins_nxt.irq_oe = |irq_req_i;
        end
        else
        begin
          // unused pins sit at logic zero
          pins_nxt.irq = 1'b0;
          pins_nxt.irq_oe = 1'b1;
        end
        stat_nxt.cts = !modem_in_i[ch].cts_n;
        stat_nxt.dsr = !modem_in_i[ch].dsr_n;
        stat_nxt.cts_hold = cts_hold;
        stat_nxt.rts_hold = pins_r.rts_n;
        stat_nxt.frame_err = ferr_r;
        stat_nxt.overrun = ovr_r;
      end

      always_ff @(posedge mclk_i)
      begin
        if (!rst_b_i)
        begin
          rstate_r <= uart_pin_pkg::SER_IDLE;
          rshift_r <= '0;
          rbit_r <= '0;
          rtick_r <= '0;
          ir_cnt_r <= '0;
          rdata_r <= '0;
          rvalid_r <= 1'b0;
          ferr_r <= 1'b0;
          ovr_r <= 1'b0;
          pins_r <= '{tx: 1'b1, rts_n: 1'b1, dtr_n: 1'b1, irq: 1'b0, irq_oe: 1'b0};
          stat_r <= '0;
        end
        else
        begin
          rstate_r <= rstate_nxt;
          rshift_r <= rshift_nxt;
          rbit_r <= rbit_nxt;
          rtick_r <= rtick_nxt;
          ir_cnt_r <= ir_cnt_nxt;
          rdata_r <= rdata_nxt;
          rvalid_r <= rvalid_nxt;
          ferr_r <= ferr_nxt;
          ovr_r <= ovr_nxt;
          pins_r <= pins_nxt;
          stat_r <= stat_nxt;
        end
      end

      // tx pin passes straight from the serialiser flop
      assign modem_out_o[ch] = '{tx: tx_line, rts_n: pins_r.rts_n, dtr_n: pins_r.dtr_n,
                                 irq: pins_r.irq, irq_oe: pins_r.irq_oe};
      assign status_o[ch] = stat_r;
      assign rx_data_o[ch] = rdata_r;
      assign rx_valid_o[ch] = rvalid_r;
    end
  endgenerate

endmodule : uart_modem_pin_interface
`default_nettype wire

// ==== uart_pin_pkg.sv ====
// shared constants, field positions, states and carriers for the quad uart pin block
package uart_pin_pkg;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_HZ = 25_000_000;
  localparam int BIT_CLKS = 16;
  // infrared pulse is 3/16 of a bit period
  localparam int IR_PULSE_CLKS = (BIT_CLKS * 3) / 16;
  localparam int RX_MID_CLKS = BIT_CLKS / 2;

  // ---------------------------------------------------------------
  // control register field positions and reset values
  // ---------------------------------------------------------------
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_INT_EN_BIT = 3;
  localparam int MCR_IR_BIT = 6;
  localparam int EFR_AUTO_RTS_BIT = 6;
  localparam int EFR_AUTO_CTS_BIT = 7;
  localparam int IER_RTS_INT_BIT = 6;
  localparam int IER_CTS_INT_BIT = 7;
  localparam logic [7:0] MCR_RESET = 8'h00;

  // build strap for the interrupt-select pin
  localparam logic [1:0] STRAP_PIN = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_LOW = 2'h2;

  // ---------------------------------------------------------------
  // state machines
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA = 4'b0100,
    SER_STOP = 4'b1000
  } ser_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rx;
    logic cts_n;
    logic dsr_n;
  } modem_in_t;

  typedef struct packed {
    logic tx;
    logic rts_n;
    logic dtr_n;
    logic irq;
    logic irq_oe;
  } modem_out_t;

  typedef struct packed {
    logic cts;
    logic dsr;
    logic cts_hold;
    logic rts_hold;
    logic frame_err;
    logic overrun;
  } chan_status_t;

endpackage : uart_pin_pkg

// ==== uart_tx_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module uart_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push)
    begin
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

endmodule : uart_tx_fifo
`default_nettype wire

// ==== uart_serial_tx.sv ====
// one-channel serialiser: 8n1 framing with optional infrared pulse encoding
`timescale 1ns/1ns
`default_nettype none
module uart_serial_tx #(
  parameter int BIT_CLKS = uart_pin_pkg::BIT_CLKS,
  parameter int IR_PULSE_CLKS = uart_pin_pkg::IR_PULSE_CLKS
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic infrared_i,
  input wire logic cts_hold_i,
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic tx_o
);

  localparam int TW = $clog2(BIT_CLKS);

  uart_pin_pkg::ser_state_t state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [TW-1:0] tick_r, tick_nxt;
  logic tx_r, tx_nxt;
  logic line;
  logic tick_end;

  assign tick_end = (tick_r == TW'(BIT_CLKS - 1));
  // a held transmitter finishes its character, then waits
  assign ready_o = (state_r == uart_pin_pkg::SER_IDLE) && !cts_hold_i;
  assign tx_o = tx_r;

  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    tick_nxt = tick_end ? '0 : tick_r + 1'b1;
    line = 1'b1;
    case (state_r)
      uart_pin_pkg::SER_IDLE:
      begin
        tick_nxt = '0;
        if (valid_i && ready_o)
        begin
          shift_nxt = data_i;
          state_nxt = uart_pin_pkg::SER_START;
        end
      end
      uart_pin_pkg::SER_START:
      begin
        line = 1'b0;
        if (tick_end)
        begin
          bit_nxt = '0;
          state_nxt = uart_pin_pkg::SER_DATA;
        end
      end
      uart_pin_pkg::SER_DATA:
      begin
        line = shift_r[0];
        if (tick_end)
        begin
          shift_nxt = {1'b0, shift_r[7:1]};
          bit_nxt = bit_r + 1'b1;
          if (bit_r == 3'h7)
          begin
            state_nxt = uart_pin_pkg::SER_STOP;
          end
        end
      end
      uart_pin_pkg::SER_STOP:
      begin
        if (tick_end)
        begin
          state_nxt = uart_pin_pkg::SER_IDLE;
        end
      end
      default:
      begin
        state_nxt = uart_pin_pkg::SER_IDLE;
      end
    endcase
    // infrared: a zero bit is a short high pulse, idle and one bits are low
    if (infrared_i)
    begin
      tx_nxt = !line && (tick_r < TW'(IR_PULSE_CLKS));
    end
    else
    begin
      tx_nxt = line;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= uart_pin_pkg::SER_IDLE;
      shift_r <= '0;
      bit_r <= '0;
      tick_r <= '0;
      tx_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      tick_r <= tick_nxt;
      tx_r <= tx_nxt;
    end
  end

endmodule : uart_serial_tx
`default_nettype wire

// ==== uart_pin_props.sv ====
// assertion checker for the quad uart pin block
`timescale 1ns/1ns
`default_nettype none
module uart_pin_props #(
  parameter int NUM_CH = 4,
  parameter int BIT_CLKS = 16,
  parameter logic [1:0] INTERRUPT_SELECT_PIN_STRAP = uart_pin_pkg::STRAP_PIN
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic bus_type_i,
  input wire logic interrupt_select_pin_i,
  input wire logic [NUM_CH-1:0][7:0] modem_control_reg_i,
  input wire logic [NUM_CH-1:0][7:0] enhanced_feature_reg_i,
  input wire logic [NUM_CH-1:0] irq_req_i,
  input wire uart_pin_pkg::modem_out_t [NUM_CH-1:0] modem_out_o
);
  logic [NUM_CH-1:0] oe_w, irq_w, tx_w, rts_w, dtr_w, m0_w, m1_w, m3_w, m6_w, e6_w;
  int low_cnt_r;
  logic sel_w;
  // strapped builds ignore the pin
  assign sel_w = (INTERRUPT_SELECT_PIN_STRAP == uart_pin_pkg::STRAP_PIN) ? interrupt_select_pin_i
                 : (INTERRUPT_SELECT_PIN_STRAP == uart_pin_pkg::STRAP_HIGH);
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      oe_w[c] = modem_out_o[c].irq_oe;
      irq_w[c] = modem_out_o[c].irq;
      tx_w[c] = modem_out_o[c].tx;
      rts_w[c] = modem_out_o[c].rts_n;
      dtr_w[c] = modem_out_o[c].dtr_n;
      m0_w[c] = modem_control_reg_i[c][uart_pin_pkg::MCR_DTR_BIT];
      m1_w[c] = modem_control_reg_i[c][uart_pin_pkg::MCR_RTS_BIT];
      m3_w[c] = modem_control_reg_i[c][uart_pin_pkg::MCR_INT_EN_BIT];
      m6_w[c] = modem_control_reg_i[c][uart_pin_pkg::MCR_IR_BIT];
      e6_w[c] = enhanced_feature_reg_i[c][uart_pin_pkg::EFR_AUTO_RTS_BIT];
    end
  end
  // a standard frame only ever holds whole bit times low
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i || tx_w[0])
      low_cnt_r <= 0;
    else
      low_cnt_r <= low_cnt_r + 1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  chk_sel_forces_on: assert property (bus_type_i && sel_w |=> &oe_w)
    else $error("interrupt pins not driven with select high");
  chk_bit3_gates_oe: assert property (bus_type_i && !sel_w |=> oe_w == $past(m3_w))
    else $error("interrupt enable does not follow control bit 3");
  chk_irq_follows_req: assert property (bus_type_i |=> irq_w == $past(irq_req_i))
    else $error("interrupt level does not follow request");
  chk_alt_spare_pins: assert property (!bus_type_i |=> irq_w == '0 && &oe_w[NUM_CH-1:1])
    else $error("alternate mode spare interrupt pins wrong");
  chk_alt_open_drain: assert property (!bus_type_i |=> oe_w[0] == |$past(irq_req_i))
    else $error("alternate mode shared interrupt pin wrong");
  chk_reset_out_idle: assert property ($rose(rst_b_i) |-> &tx_w && &rts_w && &dtr_w && oe_w == '0)
    else $error("outputs not at reset levels");
  chk_dtr_tracks_bit: assert property ($past(rst_b_i) |-> dtr_w == ~$past(m0_w))
    else $error("ready output does not follow control bit 0");
  chk_rts_manual: assert property (e6_w == '0 |=> rts_w == ~$past(m1_w))
    else $error("request output does not follow control bit 1");
  chk_tx_bit_times: assert property ($rose(tx_w[0]) && !m6_w[0] |-> low_cnt_r != 0 && low_cnt_r % BIT_CLKS == 0)
    else $error("transmit low run not whole bit times");
  cover property (bus_type_i && interrupt_select_pin_i);
  cover property ($rose(tx_w[0]));
  cover property (!bus_type_i && irq_req_i[0]);
endmodule : uart_pin_props
bind uart_modem_pin_interface uart_pin_props #(.NUM_CH(NUM_CH), .BIT_CLKS(BIT_CLKS),
  .INTERRUPT_SELECT_PIN_STRAP(INTERRUPT_SELECT_PIN_STRAP)) u_props (
  .mclk_i(mclk_i),
  .rst_b_i(rst_b_i),
  .bus_type_i(bus_type_i),
  .interrupt_select_pin_i(interrupt_select_pin_i),
  .modem_control_reg_i(modem_control_reg_i),
  .enhanced_feature_reg_i(enhanced_feature_reg_i),
  .irq_req_i(irq_req_i),
  .modem_out_o(modem_out_o)
);
`default_nettype wire

// ==== remote_uart_model.sv ====
// far-end serial party for channel 0: sends and receives 8n1 frames
`timescale 1ns/1ns
`default_nettype none
module remote_uart_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic mclk_i,
  input wire logic tx_i,
  output logic rx_o
);
  initial rx_o = 1'b1;
  // a low stop bit makes a broken frame on purpose
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_o = f[i];
      repeat (BIT_CLKS) @(negedge mclk_i);
    end
    rx_o = 1'b1;
  endtask : send_byte
  // sampled on the falling edge, away from the block's own updates
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    for (n = 0; n < 4000 && tx_i !== 1'b0; n++) @(negedge mclk_i);
    if (n < 4000)
    begin
      repeat (BIT_CLKS / 2) @(negedge mclk_i);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CLKS) @(negedge mclk_i);
        b[i] = tx_i;
      end
      repeat (BIT_CLKS) @(negedge mclk_i);
      ok = (tx_i === 1'b1);
    end
  endtask : get_byte
endmodule : remote_uart_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the quad uart pin block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int BT = 16;
  typedef struct packed {
    logic bt;
    logic sel;
    logic [3:0] m3;
    logic [3:0] m0;
    logic [3:0] req;
    logic [3:0] oe;
    logic [3:0] irq;
  } row_t;
  row_t rows [6] = '{
    '{1'b1, 1'b1, 4'h0, 4'h5, 4'h5, 4'hf, 4'h5},
    '{1'b1, 1'b0, 4'h0, 4'ha, 4'ha, 4'h0, 4'ha},
    '{1'b1, 1'b0, 4'h6, 4'h3, 4'hc, 4'h6, 4'hc},
    '{1'b1, 1'b0, 4'hf, 4'h0, 4'hf, 4'hf, 4'hf},
    '{1'b0, 1'b0, 4'hf, 4'h0, 4'h0, 4'he, 4'h0},
    '{1'b0, 1'b0, 4'h0, 4'hf, 4'h8, 4'hf, 4'h0}
  };
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic bt = 1'b1;
  logic sel = 1'b0;
  logic rx_line;
  logic [3:0] m0 = 4'h0, m3 = 4'h0, m6 = 4'h0, e6 = 4'h0, e7 = 4'h0, req = 4'h0;
  logic [3:0] txv = 4'h0, rxr = 4'h0, cts_n = 4'h0, dsr_n = 4'hf;
  logic [3:0] txr, rxv, oe_v, irq_v, tx_v, rts_v, dtr_v, oe_hi, oe_lo;
  logic [3:0][7:0] modem_control_reg, enhanced_feature_reg, rxd;
  logic [3:0][7:0] txd = '0;
  uart_pin_pkg::modem_in_t [3:0] min;
  uart_pin_pkg::modem_out_t [3:0] mout, mout_hi, mout_lo;
  uart_pin_pkg::chan_status_t [3:0] st;
  int bad_count = 0;
  int num_checks = 0;
  logic ovr_seen = 1'b0;
  logic ferr_seen = 1'b0;
  always #20 mclk_i = ~mclk_i;
  // error flags only pulse for a cycle, so keep them
  always @(posedge mclk_i)
  begin
    if (st[0].overrun === 1'b1)
      ovr_seen <= 1'b1;
    if (st[0].frame_err === 1'b1)
      ferr_seen <= 1'b1;
  end
  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      modem_control_reg[c] = {1'b0, m6[c], 2'b00, m3[c], 1'b0, m0[c], m0[c]};
      enhanced_feature_reg[c] = {e7[c], e6[c], 6'h00};
      min[c].rx = (c == 0) ? rx_line : ~m6[c];
      min[c].cts_n = cts_n[c];
      min[c].dsr_n = dsr_n[c];
      {tx_v[c], rts_v[c], dtr_v[c], irq_v[c], oe_v[c]} = mout[c];
      oe_hi[c] = mout_hi[c].irq_oe;
      oe_lo[c] = mout_lo[c].irq_oe;
    end
  end
  uart_modem_pin_interface #(.BIT_CLKS(BT)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_type_i(bt), .interrupt_select_pin_i(sel),
    .modem_control_reg_i(modem_control_reg), .enhanced_feature_reg_i(enhanced_feature_reg), .interrupt_enable_reg_i('0),
    .irq_req_i(req), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd),
    .rx_valid_o(rxv), .rx_ready_i(rxr), .modem_in_i(min), .modem_out_o(mout), .status_o(st)
  );
  remote_uart_model #(.BIT_CLKS(BT)) far (.mclk_i(mclk_i), .tx_i(tx_v[0]), .rx_o(rx_line));
  // strapped builds: only their interrupt enables are watched
  uart_modem_pin_interface #(.BIT_CLKS(BT), .INTERRUPT_SELECT_PIN_STRAP(uart_pin_pkg::STRAP_HIGH)) dut_hi (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_type_i(bt), .interrupt_select_pin_i(sel),
    .modem_control_reg_i(modem_control_reg), .enhanced_feature_reg_i(enhanced_feature_reg), .interrupt_enable_reg_i('0),
    .irq_req_i(req), .tx_data_i(txd), .tx_valid_i(4'h0), .tx_ready_o(), .rx_data_o(),
    .rx_valid_o(), .rx_ready_i(rxr), .modem_in_i(min), .modem_out_o(mout_hi), .status_o()
  );
  uart_modem_pin_interface #(.BIT_CLKS(BT), .INTERRUPT_SELECT_PIN_STRAP(uart_pin_pkg::STRAP_LOW)) dut_lo (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_type_i(bt), .interrupt_select_pin_i(sel),
    .modem_control_reg_i(modem_control_reg), .enhanced_feature_reg_i(enhanced_feature_reg), .interrupt_enable_reg_i('0),
    .irq_req_i(req), .tx_data_i(txd), .tx_valid_i(4'h0), .tx_ready_o(), .rx_data_o(),
    .rx_valid_o(), .rx_ready_i(rxr), .modem_in_i(min), .modem_out_o(mout_lo), .status_o()
  );
  task automatic fail(input string what);
    bad_count++;
    $display("mismatch t=%0t %s", $time, what);
  endtask : fail
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
      fail(what);
  endtask : cmp
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    int n;
    int hi;
    logic [7:0] b;
    logic ok;
    repeat (8) @(negedge mclk_i);
    cmp(8'({tx_v, dtr_v}), 8'hff, "reset levels");
    $display("reset test done");
    rst_b_i = 1'b1;
    foreach (rows[i])
    begin
      {bt, sel, m3, m0, req} = {rows[i].bt, rows[i].sel, rows[i].m3, rows[i].m0, rows[i].req};
      repeat (2) @(negedge mclk_i);
      cmp(8'(oe_v), 8'(rows[i].oe), "irq enable");
      cmp(8'(irq_v), 8'(rows[i].irq), "irq level");
      cmp(8'({dtr_v, rts_v}), 8'({~rows[i].m0, ~rows[i].m0}), "modem outs");
      cmp(8'(oe_hi), rows[i].bt ? 8'h0f : 8'(rows[i].oe), "strap high enable");
      cmp(8'(oe_lo), 8'(rows[i].bt ? rows[i].m3 : rows[i].oe), "strap low enable");
    end
    $display("table rows done");
    {bt, e7[0], cts_n[0]} = 3'b111;
    for (int i = 0; i < 32; i++)
    begin
      txd[0] = 8'(8'h40 + i);
      txv[0] = 1'b1;
      @(negedge mclk_i);
    end
    txv[0] = 1'b0;
    repeat (64) @(negedge mclk_i);
    cmp(8'({txr[0], tx_v[0], st[0].cts_hold, st[0].cts}), 8'h06, "held while clear high");
    cts_n[0] = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      far.get_byte(b, ok);
      if (!ok)
      begin
        fail("no frame");
        tally_and_finish();
      end
      cmp(b, 8'(8'h40 + i), "tx byte");
    end
    cmp(8'({txr[0], st[0].cts, st[0].cts_hold}), 8'h06, "fifo drained");
    $display("fifo and clear-to-send test done");
    m0[0] = 1'b1;
    repeat (2) @(negedge mclk_i);
    {e6[0], dsr_n[0]} = 2'b10;
    far.send_byte(8'h3c, 1'b1);
    for (n = 0; n < 64 && rxv[0] !== 1'b1; n++) @(negedge mclk_i);
    if (n == 64)
    begin
      fail("no rx byte");
      tally_and_finish();
    end
    cmp(rxd[0], 8'h3c, "rx byte");
    cmp(8'({st[0].dsr, rts_v[0], st[0].rts_hold}), 8'h07, "dsr status, auto rts off");
    rxr[0] = 1'b1;
    @(negedge mclk_i);
    rxr[0] = 1'b0;
    repeat (2) @(negedge mclk_i);
    cmp(8'({rxv[0], rts_v[0], st[0].rts_hold}), 8'h00, "auto rts back on");
    $display("receive and request-to-send test done");
    far.send_byte(8'h5a, 1'b1);
    far.send_byte(8'ha5, 1'b1);
    cmp(8'({rxv[0], ovr_seen, ferr_seen}), 8'h06, "overrun flagged");
    far.send_byte(8'h0f, 1'b0);
    cmp(8'(ferr_seen), 8'h01, "frame error flagged");
    cmp(rxd[0], 8'ha5, "newest good byte kept");
    $display("receive error test done");
    m6[1] = 1'b1;
    repeat (4) @(negedge mclk_i);
    cmp(8'(tx_v[1]), 8'h00, "infrared idle");
    txd[1] = 8'h00;
    txv[1] = 1'b1;
    @(negedge mclk_i);
    txv[1] = 1'b0;
    hi = 0;
    repeat (12 * BT) @(negedge mclk_i) hi += int'(tx_v[1] === 1'b1);
    cmp(8'(hi), 8'(9 * ((BT * 3) / 16)), "infrared pulses");
    $display("infrared test done");
    m6 = 4'h0;
    rst_b_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    cmp(8'({tx_v, dtr_v}), 8'hff, "mid-run reset");
    rst_b_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    cmp(8'({dtr_v, rts_v}), 8'h00, "outputs after second reset");
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
